// ### hdl/uap_top.sv
// What this block does
// - sixteen samples per bit, eight in double speed
// - vote samples start at 8, or 4
// - middle vote sample is 9, or 5
// - bit value is two-of-three majority
// - double speed halves divider ratio 16 to 8
// - filter mode drops non-address frames
// - transmitter ignores address filter mode
// - filter inactive while extended mode set
// - frame type from stop or ninth bit
// - type one address, zero data
// - data port writes transmit, reads receive
// - unused upper bits ignored, read zero
// - data write ignored while buffer full
// - buffer moves to empty shifter, shifted out
// - receive buffer two-entry fifo advancing on access
// - receive complete while fifo holds data; flush
// - transmit complete sets at idle, clears
// - buffer empty flag, one after reset
// - empty and receive flags request interrupts
// - receive interrupt needs enable, global, flag
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module uap_top
   import uap_pkg::*;
#(
   parameter int BAUD_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_input_pin,
   output logic serial_output_pin,
   output logic serial_output_oe,
   input wire logic global_irq_enable,
   input wire logic tx_complete_irq_ack,
   output logic rx_complete_irq,
   output logic tx_complete_irq,
   output logic tx_empty_irq
);

   // character length from size setting, 5..9
   function automatic logic [3:0] uap_nbits(input logic [2:0] csz);
      if (csz == UAP_CSZ_9BIT) begin
         return UAP_NBITS_9;
      end
      return UAP_NBITS_BASE + {2'h0, csz[1:0]};
   endfunction

   // clear data bits above the character length
   function automatic logic [8:0] uap_mask(input logic [8:0] d, input logic [3:0] n);
      logic [8:0] m;
      m = 9'h000;
      for (int i = 0; i < 9; i++) begin
         m[i] = d[i] & (4'(i) < n);
      end
      return m;
   endfunction

   // registers
   logic [7:0] ctlb_ff;
   logic [7:0] ctlc_ff;
   logic double_speed_select_ff;
   logic address_filter_mode_ff;
   logic [BAUD_W-1:0] baud_divisor_ff;
   logic tx_complete_flag_ff;
   logic overrun_flag_ff;
   // apb answer
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic pop_ok_ff;
   // input synchroniser and sampling clock
   logic rxd_meta_ff;
   logic rxd_sync_ff;
   logic [BAUD_W-1:0] baud_cnt_ff;
   // receiver
   uap_rx_state_type rx_state_ff;
   logic [4:0] rx_smp_ff;
   logic [3:0] rx_idx_ff;
   logic [8:0] rx_shift_ff;
   logic [1:0] rx_vote_ff;
   logic rx_par_ff;
   logic rx_done_ff;
   logic [10:0] rx_word_ff;
   logic rx_type_ff;
   // receive fifo
   logic [10:0] fifo_mem_ff [2];
   logic fifo_wr_ff;
   logic fifo_rd_ff;
   logic [1:0] fifo_cnt_ff;
   // transmitter
   logic [8:0] tx_buf_ff;
   logic tx_buf_valid_ff;
   uap_tx_state_type tx_state_ff;
   logic [4:0] tx_smp_ff;
   logic [3:0] tx_idx_ff;
   logic [8:0] tx_shift_ff;
   logic tx_out_ff;
   logic tx_oe_ff;
   logic tx_done_ff;
   // interrupt requests
   logic rx_irq_ff;
   logic txc_irq_ff;
   logic tx_buffer_empty_flag_irq_ff;

   // configuration decode
   wire rx_enable = ctlb_ff[UAP_B_RXEN];
   wire tx_enable = ctlb_ff[UAP_B_TXEN];
   wire parity_on = ctlc_ff[UAP_B_UPM1];
   wire parity_odd = ctlc_ff[UAP_B_UPM0];
   wire ext_mode = ctlc_ff[UAP_B_EXT];
   wire [2:0] csz = {ctlb_ff[UAP_B_CSZ2], ctlc_ff[UAP_B_CSZ1], ctlc_ff[UAP_B_CSZ0]};
   wire [3:0] nbits = uap_nbits(csz);
   wire [3:0] nstops = ctlc_ff[UAP_B_STOP_BITS_SELECT] ? 4'h2 : 4'h1;
   wire [4:0] spb = double_speed_select_ff ? UAP_SPB_DBL : UAP_SPB_NORM;
   wire [4:0] vote_first = double_speed_select_ff ? UAP_VOTE_FIRST_DBL : UAP_VOTE_FIRST_NORM;
   wire [4:0] vote_mid = double_speed_select_ff ? UAP_VOTE_MID_DBL : UAP_VOTE_MID_NORM;
   wire [4:0] vote_last = vote_mid + 5'h01;
   wire filter_on = address_filter_mode_ff & ~ext_mode;

   // apb address decode
   wire is_data = (paddr == UAP_OFS_DATA);
   wire is_stat = (paddr == UAP_OFS_STAT);
   wire is_ctlb = (paddr == UAP_OFS_CTLB);
   wire is_ctlc = (paddr == UAP_OFS_CTLC);
   wire is_baud = (paddr == UAP_OFS_BAUD);
   wire mapped = is_data | is_stat | is_ctlb | is_ctlc | is_baud;
   wire access_first = psel & penable & ~pready_ff;
   wire access_done = psel & penable & pready_ff;
   wire wr_en = access_done & pwrite & mapped;
   wire data_wr = wr_en & is_data;
   wire data_pop = access_done & ~pwrite & is_data & pop_ok_ff;

   // fifo head and status view
   wire rx_complete_flag = (fifo_cnt_ff != 2'h0);
   wire [10:0] head = rx_complete_flag ? fifo_mem_ff[fifo_rd_ff] : 11'h000;
   wire rx_ninth_bit = head[10];
   wire parity_error_flag = head[9];
   wire frame_error_flag = head[8];
   wire tx_buffer_empty_flag = ~tx_buf_valid_ff;
   wire [7:0] stat_view = {rx_complete_flag, tx_complete_flag_ff, tx_buffer_empty_flag,
                           frame_error_flag, overrun_flag_ff, parity_error_flag,
                           double_speed_select_ff, address_filter_mode_ff};
   wire [7:0] ctlb_view = {ctlb_ff[7:2], rx_ninth_bit, ctlb_ff[UAP_B_TX_NINTH_BIT]};

   // read data selection
   wire [31:0] rd_mux =
      is_data ? {24'h000000, head[7:0]} :
      is_stat ? {24'h000000, stat_view} :
      is_ctlb ? {24'h000000, ctlb_view} :
      is_ctlc ? {24'h000000, ctlc_ff} :
      is_baud ? {{(32-BAUD_W){1'b0}}, baud_divisor_ff} : 32'h00000000;

   // apb answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pop_ok_ff <= 1'b0;
      end else begin
         pready_ff <= access_first;
         pslverr_ff <= access_first & ~mapped;
         prdata_ff <= access_first ? rd_mux : prdata_ff;
         pop_ok_ff <= access_first & is_data & ~pwrite & rx_complete_flag;
      end
   end

   // software writable control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctlb_ff <= UAP_RST_CTLB;
         ctlc_ff <= UAP_RST_CTLC;
         double_speed_select_ff <= UAP_RST_STAT_RW[1];
         address_filter_mode_ff <= UAP_RST_STAT_RW[0];
         baud_divisor_ff <= '0;
      end else if (wr_en) begin
         if (is_ctlb) begin
            ctlb_ff <= pwdata[7:0];
         end else if (is_ctlc) begin
            ctlc_ff <= pwdata[7:0];
         end else if (is_stat) begin
            double_speed_select_ff <= pwdata[UAP_B_U2X];
            address_filter_mode_ff <= pwdata[UAP_B_ADDRESS_FILTER_MODE];
         end else if (is_baud) begin
            baud_divisor_ff <= pwdata[BAUD_W-1:0];
         end
      end
   end

   // sampling tick every divisor plus one clocks
   wire sample_tick = (baud_cnt_ff == '0);
   wire [BAUD_W-1:0] nxt_baud_cnt = sample_tick ? baud_divisor_ff : baud_cnt_ff - 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_cnt_ff <= '0;
         rxd_meta_ff <= 1'b1;
         rxd_sync_ff <= 1'b1;
      end else begin
         baud_cnt_ff <= nxt_baud_cnt;
         rxd_meta_ff <= serial_input_pin;
         rxd_sync_ff <= rxd_meta_ff;
      end
   end

   // majority of two stored samples and the current one
   wire voted = (rx_vote_ff[0] & rx_vote_ff[1]) | (rxd_sync_ff & (rx_vote_ff[0] | rx_vote_ff[1]));
   wire rx_at_vote = sample_tick & (rx_smp_ff == vote_last);
   wire rx_bit_end = sample_tick & (rx_smp_ff == spb);
   wire [8:0] rx_data = uap_mask(rx_shift_ff, nbits);
   wire rx_par_bad = parity_on & ((^rx_data) ^ parity_odd ^ rx_par_ff);
   wire rx_frame_type = (nbits == UAP_NBITS_9) ? rx_shift_ff[8] : voted;

   // receiver state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_ff <= UAP_RX_IDLE;
         rx_smp_ff <= UAP_SMP_FIRST;
         rx_idx_ff <= 4'h0;
         rx_shift_ff <= 9'h000;
         rx_vote_ff <= 2'h3;
         rx_par_ff <= 1'b0;
         rx_done_ff <= 1'b0;
         rx_word_ff <= 11'h000;
         rx_type_ff <= 1'b0;
      end else begin
         rx_done_ff <= 1'b0;
         if (!rx_enable) begin
            rx_state_ff <= UAP_RX_IDLE; // reception dropped at once
         end else if (sample_tick) begin
            rx_smp_ff <= rx_bit_end ? UAP_SMP_FIRST : rx_smp_ff + 5'h01;
            if (rx_smp_ff == vote_first) begin
               rx_vote_ff[0] <= rxd_sync_ff;
            end
            if (rx_smp_ff == vote_mid) begin
               rx_vote_ff[1] <= rxd_sync_ff;
            end
            case (rx_state_ff)
               UAP_RX_IDLE: begin
                  if (!rxd_sync_ff) begin
                     rx_state_ff <= UAP_RX_START;
                     rx_smp_ff <= UAP_SMP_FIRST + 5'h01; // this sample is sample 1
                     rx_shift_ff <= 9'h000;
                  end else begin
                     rx_smp_ff <= UAP_SMP_FIRST;
                  end
               end
               UAP_RX_START: begin
                  if (rx_at_vote && voted) begin
                     rx_state_ff <= UAP_RX_IDLE; // noise spike rejected
                     rx_smp_ff <= UAP_SMP_FIRST;
                  end else if (rx_bit_end) begin
                     rx_state_ff <= UAP_RX_DATA;
                     rx_idx_ff <= 4'h0;
                  end
               end
               UAP_RX_DATA: begin
                  if (rx_at_vote) begin
                     rx_shift_ff[rx_idx_ff] <= voted;
                  end
                  if (rx_bit_end) begin
                     rx_idx_ff <= rx_idx_ff + 4'h1;
                     if (rx_idx_ff == nbits - 4'h1) begin
                        rx_state_ff <= parity_on ? UAP_RX_PAR : UAP_RX_STOP;
                     end
                  end
               end
               UAP_RX_PAR: begin
                  if (rx_at_vote) begin
                     rx_par_ff <= voted;
                  end
                  if (rx_bit_end) begin
                     rx_state_ff <= UAP_RX_STOP;
                  end
               end
               UAP_RX_STOP: begin
                  if (rx_at_vote) begin
                     rx_state_ff <= UAP_RX_IDLE; // next start may follow at once
                     rx_smp_ff <= UAP_SMP_FIRST;
                     rx_done_ff <= 1'b1;
                     rx_word_ff <= {rx_data[8], rx_par_bad, ~voted, rx_data[7:0]};
                     rx_type_ff <= rx_frame_type;
                  end
               end
               default: begin
                  rx_state_ff <= UAP_RX_IDLE;
               end
            endcase
         end
      end
   end

   // fifo push, kept frames only
   wire rx_keep = rx_done_ff & (rx_type_ff | ~filter_on);
   wire fifo_full = (fifo_cnt_ff == UAP_FIFO_FULL);
   wire fifo_push = rx_keep & (~fifo_full | data_pop);
   wire rx_lost = rx_keep & fifo_full & ~data_pop;
   wire [1:0] nxt_fifo_cnt = fifo_cnt_ff + {1'b0, fifo_push} - {1'b0, data_pop};

   // two-entry receive fifo, flushed when receiver off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_mem_ff[0] <= 11'h000;
         fifo_mem_ff[1] <= 11'h000;
         fifo_wr_ff <= 1'b0;
         fifo_rd_ff <= 1'b0;
         fifo_cnt_ff <= 2'h0;
      end else if (!rx_enable) begin
         fifo_wr_ff <= 1'b0;
         fifo_rd_ff <= 1'b0;
         fifo_cnt_ff <= 2'h0;
      end else begin
         if (fifo_push) begin
            fifo_mem_ff[fifo_wr_ff] <= rx_word_ff;
            fifo_wr_ff <= ~fifo_wr_ff;
         end
         if (data_pop) begin
            fifo_rd_ff <= ~fifo_rd_ff;
         end
         fifo_cnt_ff <= nxt_fifo_cnt;
      end
   end

   // overrun: lost frame marked until next data read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag_ff <= 1'b0;
      end else if (!rx_enable) begin
         overrun_flag_ff <= 1'b0;
      end else if (rx_lost) begin
         overrun_flag_ff <= 1'b1;
      end else if (data_pop) begin
         overrun_flag_ff <= 1'b0;
      end
   end

   // transmit side, independent of filter mode
   wire tx_bit_end = sample_tick & (tx_smp_ff == spb);
   wire tx_load = tx_buf_valid_ff & tx_oe_ff & (tx_state_ff == UAP_TX_IDLE);
   wire tx_take = data_wr & ~tx_buf_valid_ff;
   wire [8:0] tx_data = uap_mask(tx_shift_ff, nbits);
   wire tx_parity = (^tx_data) ^ parity_odd;

   // transmit buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf_ff <= 9'h000;
         tx_buf_valid_ff <= 1'b0;
      end else if (tx_take) begin
         tx_buf_ff <= {ctlb_ff[UAP_B_TX_NINTH_BIT], pwdata[7:0]};
         tx_buf_valid_ff <= 1'b1;
      end else if (tx_load) begin
         tx_buf_valid_ff <= 1'b0;
      end
   end

   // transmit shifter state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_ff <= UAP_TX_IDLE;
         tx_smp_ff <= UAP_SMP_FIRST;
         tx_idx_ff <= 4'h0;
         tx_shift_ff <= 9'h000;
         tx_out_ff <= 1'b1;
         tx_done_ff <= 1'b0;
      end else begin
         tx_done_ff <= 1'b0;
         if (tx_load) begin
            tx_state_ff <= UAP_TX_START;
            tx_shift_ff <= tx_buf_ff;
            tx_smp_ff <= UAP_SMP_FIRST;
            tx_out_ff <= 1'b0;
         end else if (sample_tick && tx_state_ff != UAP_TX_IDLE) begin
            tx_smp_ff <= tx_bit_end ? UAP_SMP_FIRST : tx_smp_ff + 5'h01;
            if (tx_bit_end) begin
               case (tx_state_ff)
                  UAP_TX_START: begin
                     tx_state_ff <= UAP_TX_DATA;
                     tx_idx_ff <= 4'h0;
                     tx_out_ff <= tx_data[0];
                  end
                  UAP_TX_DATA: begin
                     if (tx_idx_ff == nbits - 4'h1) begin
                        tx_state_ff <= parity_on ? UAP_TX_PAR : UAP_TX_STOP;
                        tx_out_ff <= parity_on ? tx_parity : 1'b1;
                        tx_idx_ff <= 4'h0;
                     end else begin
                        tx_idx_ff <= tx_idx_ff + 4'h1;
                        tx_out_ff <= tx_data[tx_idx_ff + 4'h1];
                     end
                  end
                  UAP_TX_PAR: begin
                     tx_state_ff <= UAP_TX_STOP;
                     tx_out_ff <= 1'b1;
                  end
                  UAP_TX_STOP: begin
                     if (tx_idx_ff == nstops - 4'h1) begin
                        tx_state_ff <= UAP_TX_IDLE;
                        tx_done_ff <= 1'b1;
                     end else begin
                        tx_idx_ff <= tx_idx_ff + 4'h1;
                     end
                  end
                  default: begin
                     tx_state_ff <= UAP_TX_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // pin drive held until pending frames are sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_oe_ff <= 1'b0;
      end else begin
         tx_oe_ff <= tx_enable | tx_buf_valid_ff | (tx_state_ff != UAP_TX_IDLE) | tx_load;
      end
   end

   // transmit complete: set wins over clear
   wire txc_clear = tx_complete_irq_ack | (wr_en & is_stat & pwdata[UAP_B_TXC]);
   wire txc_set = tx_done_ff & ~tx_buf_valid_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_complete_flag_ff <= 1'b0;
      end else if (txc_set) begin
         tx_complete_flag_ff <= 1'b1;
      end else if (txc_clear) begin
         tx_complete_flag_ff <= 1'b0;
      end
   end

   // interrupt requests gated by enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq_ff <= 1'b0;
         txc_irq_ff <= 1'b0;
         tx_buffer_empty_flag_irq_ff <= 1'b0;
      end else begin
         rx_irq_ff <= ctlb_ff[UAP_B_RX_COMPLETE_IRQ_ENABLE] & global_irq_enable & rx_complete_flag;
         txc_irq_ff <= ctlb_ff[UAP_B_TX_COMPLETE_IRQ_ENABLE] & global_irq_enable & tx_complete_flag_ff;
         tx_buffer_empty_flag_irq_ff <= ctlb_ff[UAP_B_TX_EMPTY_IRQ_ENABLE] & global_irq_enable & tx_buffer_empty_flag;
      end
   end

   // outputs
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign serial_output_pin = tx_out_ff;
   assign serial_output_oe = tx_oe_ff;
   assign rx_complete_irq = rx_irq_ff;
   assign tx_complete_irq = txc_irq_ff;
   assign tx_empty_irq = tx_buffer_empty_flag_irq_ff;

endmodule // uap_top
`default_nettype wire

// ### hdl/uap_pkg.sv
`default_nettype none
// shared constants of the serial transceiver block
package uap_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] UAP_OFS_DATA = 8'h00;
   localparam logic [7:0] UAP_OFS_STAT = 8'h04;
   localparam logic [7:0] UAP_OFS_CTLB = 8'h08;
   localparam logic [7:0] UAP_OFS_CTLC = 8'h0c;
   localparam logic [7:0] UAP_OFS_BAUD = 8'h10;
   // status_control_a field positions
   localparam int UAP_B_RXC = 7;
   localparam int UAP_B_TXC = 6;
   localparam int UAP_B_TX_BUFFER_EMPTY_FLAG = 5;
   localparam int UAP_B_FE = 4;
   localparam int UAP_B_DOR = 3;
   localparam int UAP_B_UPE = 2;
   localparam int UAP_B_U2X = 1;
   localparam int UAP_B_ADDRESS_FILTER_MODE = 0;
   // control_b field positions
   localparam int UAP_B_RX_COMPLETE_IRQ_ENABLE = 7;
   localparam int UAP_B_TX_COMPLETE_IRQ_ENABLE = 6;
   localparam int UAP_B_TX_EMPTY_IRQ_ENABLE = 5;
   localparam int UAP_B_RXEN = 4;
   localparam int UAP_B_TXEN = 3;
   localparam int UAP_B_CSZ2 = 2;
   localparam int UAP_B_RX_NINTH_BIT = 1;
   localparam int UAP_B_TX_NINTH_BIT = 0;
   // control_c field positions
   localparam int UAP_B_EXT = 6;
   localparam int UAP_B_UPM1 = 5;
   localparam int UAP_B_UPM0 = 4;
   localparam int UAP_B_STOP_BITS_SELECT = 3;
   localparam int UAP_B_CSZ1 = 2;
   localparam int UAP_B_CSZ0 = 1;
   // reset values
   localparam logic [7:0] UAP_RST_CTLB = 8'h00;
   localparam logic [7:0] UAP_RST_CTLC = 8'h06;
   localparam logic [1:0] UAP_RST_STAT_RW = 2'h0;
   // sampling per bit, vote window
   localparam logic [4:0] UAP_SPB_NORM = 5'h10;
   localparam logic [4:0] UAP_SPB_DBL = 5'h08;
   localparam logic [4:0] UAP_VOTE_FIRST_NORM = 5'h08;
   localparam logic [4:0] UAP_VOTE_FIRST_DBL = 5'h04;
   localparam logic [4:0] UAP_VOTE_MID_NORM = 5'h09;
   localparam logic [4:0] UAP_VOTE_MID_DBL = 5'h05;
   localparam logic [4:0] UAP_SMP_FIRST = 5'h01;
   // character size encodings
   localparam logic [2:0] UAP_CSZ_9BIT = 3'h7;
   localparam logic [3:0] UAP_NBITS_9 = 4'h9;
   localparam logic [3:0] UAP_NBITS_BASE = 4'h5;
   // fifo depth
   localparam logic [1:0] UAP_FIFO_FULL = 2'h2;
   typedef enum logic [2:0] {
      UAP_RX_IDLE = 3'b000,
      UAP_RX_START = 3'b001,
      UAP_RX_DATA = 3'b010,
      UAP_RX_PAR = 3'b011,
      UAP_RX_STOP = 3'b100
   } uap_rx_state_type;
   typedef enum logic [2:0] {
      UAP_TX_IDLE = 3'b000,
      UAP_TX_START = 3'b001,
      UAP_TX_DATA = 3'b010,
      UAP_TX_PAR = 3'b011,
      UAP_TX_STOP = 3'b100
   } uap_tx_state_type;
endpackage
`default_nettype wire

// ### tb/uap_sva.sv
`timescale 1ns/10ps
`default_nettype none
module uap_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_output_pin,
   input wire logic serial_output_oe,
   input wire logic global_irq_enable,
   input wire logic rx_complete_irq,
   input wire logic tx_complete_irq,
   input wire logic tx_empty_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // one wait state after the setup cycle
   property p_one_wait;
      (psel && !penable ##1 psel && penable) |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready late");
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
   property p_err_unmap;
      (psel && penable && !pready && (paddr > 8'h10 || paddr[1:0] != 2'h0)) |=> pslverr;
   endproperty
   a_err_unmap: assert property (p_err_unmap) else $error("no error");
   property p_err_cause;
      pslverr |-> $past(paddr > 8'h10 || paddr[1:0] != 2'h0);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("bad error");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error data");
   property p_rx_irq;
      rx_complete_irq |-> $past(global_irq_enable);
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx irq ungated");
   property p_tx_irq;
      (tx_empty_irq || tx_complete_irq) |-> $past(global_irq_enable);
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq ungated");
   property p_idle_high;
      !serial_output_oe |-> serial_output_pin;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle");
   property p_bit_min;
      $fell(serial_output_pin) |-> !serial_output_pin [*8];
   endproperty
   a_bit_min: assert property (p_bit_min) else $error("bit short");
   // main scenarios reached
   c_err: cover property (pslverr);
   c_rx_irq: cover property (rx_complete_irq);
   c_empty_irq: cover property (tx_empty_irq);
endmodule // uap_sva
bind uap_top uap_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_output_pin(serial_output_pin), .serial_output_oe(serial_output_oe),
   .global_irq_enable(global_irq_enable), .rx_complete_irq(rx_complete_irq),
   .tx_complete_irq(tx_complete_irq), .tx_empty_irq(tx_empty_irq));
`default_nettype wire

// ### tb/uap_node.sv
`timescale 1ns/10ps
`default_nettype none
// remote node driving the serial line into the block
module uap_node (
   input wire logic pclk,
   output var logic line
);
   initial line = 1'b1;
   // start bit, eight data bits, then type stop and second stop; optional one-clock glitch in the middle of every bit
   task automatic send(input logic [9:0] b, input int spb, input logic gl);
      logic [10:0] f;
      f = {b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         for (int k = 0; k < spb; k++) begin
            @(posedge pclk);
            line <= (gl && k == spb / 2) ? !f[i] : f[i];
         end
      end
      @(posedge pclk);
      line <= 1'b1;
   endtask
endmodule // uap_node
`default_nettype wire

// ### tb/uap_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module uap_top_test;
   import uap_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, gie, ack, err;
   logic txd, oe, rxi, tci, tei, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   wire rxd;
   int failures, total_checks;
   uap_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_input_pin(rxd), .serial_output_pin(txd),
      .serial_output_oe(oe), .global_irq_enable(gie), .tx_complete_irq_ack(ack),
      .rx_complete_irq(rxi), .tx_complete_irq(tci), .tx_empty_irq(tei));
   uap_node i_node (.pclk(pclk), .line(rxd));
   // clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = !pclk;
   end
   task automatic finish_test;
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // capture one 8-bit frame on the output line
   task automatic txf(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      while (txd !== 1'b0) begin
         @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         if (i > 0) repeat (16) @(posedge pclk);
         chk({31'h0, txd}, {31'h0, f[i]});
      end
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      finish_test();
   end
   initial begin
      failures = 0;
      total_checks = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, ack, paddr, pwdata} = '0;
      gie = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(UAP_OFS_STAT, 32'h20);
      rdc(8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, UAP_OFS_CTLB, 32'hf8);
      apb(1'b1, UAP_OFS_STAT, 32'h01);
      // line checker starts before the first start bit
      fork
         begin
            txf(8'ha5);
            txf(8'h3c);
         end
         begin
            apb(1'b1, UAP_OFS_DATA, 32'ha5);
            apb(1'b1, UAP_OFS_DATA, 32'h3c);
            apb(1'b1, UAP_OFS_DATA, 32'hff);
         end
      join
      repeat (16) @(posedge pclk);
      rdc(UAP_OFS_STAT, 32'h61);
      apb(1'b1, UAP_OFS_STAT, 32'h41);
      rdc(UAP_OFS_STAT, 32'h21);
      apb(1'b1, UAP_OFS_DATA, 32'h81); // frame goes out while the node talks
      i_node.send({2'b10, 8'h34}, 16, 1'b0);
      i_node.send({2'b11, 8'h12}, 16, 1'b0);
      chk({31'h0, rxi}, 32'h1);
      chk({31'h0, tei}, 32'h1);
      chk({31'h0, tci}, 32'h1);
      // interrupt executed, then global enable off
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      gie <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, rxi}, 32'h0);
      chk({31'h0, tei}, 32'h0);
      gie <= 1'b1;
      rdc(UAP_OFS_STAT, 32'ha1);
      rdc(UAP_OFS_DATA, 32'h12);
      apb(1'b1, UAP_OFS_STAT, 32'h0);
      i_node.send({2'b10, 8'h56}, 16, 1'b0);
      rdc(UAP_OFS_STAT, 32'hb0);
      rdc(UAP_OFS_DATA, 32'h56);
      for (int i = 1; i < 4; i++) begin
         i_node.send({2'b11, i[7:0]}, 16, 1'b0);
      end
      rdc(UAP_OFS_STAT, 32'ha8);
      rdc(UAP_OFS_DATA, 32'h01);
      apb(1'b1, UAP_OFS_CTLB, 32'h08);
      rdc(UAP_OFS_STAT, 32'h20);
      apb(1'b1, UAP_OFS_CTLB, 32'hf8);
      apb(1'b1, UAP_OFS_STAT, 32'h03);
      i_node.send({2'b11, 8'h96}, 8, 1'b1);
      rdc(UAP_OFS_STAT, 32'ha3);
      rdc(UAP_OFS_DATA, 32'h96);
      // nine data bits: ninth bit gives the frame type
      apb(1'b1, UAP_OFS_CTLB, 32'hfc);
      i_node.send({2'b10, 8'h5a}, 8, 1'b0);
      i_node.send({2'b11, 8'hc3}, 8, 1'b0);
      rdc(UAP_OFS_CTLB, 32'hfe);
      rdc(UAP_OFS_DATA, 32'hc3);
      // extended mode turns the filter off
      apb(1'b1, UAP_OFS_CTLC, 32'h46);
      i_node.send({2'b10, 8'h77}, 8, 1'b0);
      rdc(UAP_OFS_DATA, 32'h77);
      finish_test();
   end
endmodule // uap_top_test
`default_nettype wire
